// *** common/supply_mode_pkg.sv ***
// supply and mode supervisor shared constants and types
package supply_mode_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int FAIL_DGL_US     = 200;
    localparam int FAIL_DGL_CYCLES = (FAIL_DGL_US * 1000) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES     = 2;

    // channel counts
    localparam int NUM_POWER_OUT = 5;
    localparam int NUM_DIRECT_IN = 4;

    // reported fault flag positions
    localparam int FAULT_W         = 8;
    localparam int FLT_OPEN_LOAD   = 0;
    localparam int FLT_SHORT_BAT   = 1;
    localparam int FLT_SEVERE_GND  = 2;
    localparam int FLT_OVERCURRENT = 3;
    localparam int FLT_OVERTEMP    = 4;
    localparam int FLT_CLOCK_FAIL  = 5;
    localparam int FLT_UNDERVOLT   = 6;
    localparam int FLT_OVERVOLT    = 7;

    // reset values
    localparam logic [FAULT_W-1:0]       FAULT_RST = 8'h00;
    localparam logic [NUM_POWER_OUT-1:0] OUT_OFF   = 5'h00;

    // supply loss indications, high when the supply or ground is lost
    typedef struct packed {
        logic batLost;
        logic logicLost;
        logic gndLost;
    } supply_t;

    // bits of device status register seven
    typedef struct packed {
        logic failInput;
        logic spiFailure;
    } status7_t;

    // spi communication fault pulses
    typedef struct packed {
        logic toggleErr;
        logic timeout;
        logic frameLenErr;
    } spi_fault_t;

    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_SLEEP  = 2'b01,
        MODE_NORMAL = 2'b10,
        MODE_FAIL   = 2'b11
    } mode_t;
endpackage

// *** design/level_deglitch.sv ***
// symmetric deglitch filter: output follows input after a steady run
`timescale 1ns/1ps
module level_deglitch #(
    parameter int CYCLES = 20000
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // levels
    input  wire logic levelIn,
    output logic      levelOut
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] run_ff;

    initial begin
        if (CYCLES < 1) $error("level_deglitch: CYCLES must be at least 1");
    end

    // count cycles of disagreement; any return to agreement restarts it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_ff   <= '0;
            levelOut <= 1'b0;
        end else if (levelIn == levelOut) begin
            run_ff <= '0;
        end else if (run_ff == LAST) begin
            run_ff   <= '0;
            levelOut <= levelIn;
        end else begin
            run_ff <= run_ff + 1'b1;
        end
    end
endmodule

// *** design/level_sync.sv ***
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             srst,
    // levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;

    initial begin
        if (WIDTH < 1) $error("level_sync: WIDTH must be at least 1");
    end

    // first stage is read only by the second stage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule

// *** design/supply_mode_supervisor.sv ***
// mode, wake report and supply loss supervisor of the switch device
//
// Behaviour
// R1 - fully operational only while wake is asserted, otherwise low-quiescent sleep
// R2 - while reset/wake input is low, wake-report pin tells wake state
// R3 - awake and not woken by reset/wake input: drive wake-report pin high
// R4 - sleep or woken by reset/wake input: wake-report pin undriven, used as input
// R5 - register readback over spi only while logic supply is present
// R6 - both supplies lost: power off, all outputs off, registers and faults cleared
// R7 - battery lost, logic present: keep registers and faults, outputs one-five off
// R8 - battery lost, logic present: external switch output follows its spi setting
// R9 - wake-up during battery loss is not shown on wake-report pin
// R10 - logic supply lost, battery present: take spi watchdog timeout path
// R11 - ground lost: power outputs one to five switched off
// R12 - normal mode: power outputs driven by internal pwm module
// R13 - report open load, shorts, overcurrent, overtemp, clock, under and overvoltage
// R14 - direct input control only in fail mode, forced by fail-mode pin
// R15 - fail-mode input high enters fail mode
// R16 - fail mode: each power output follows its direct input; output five has no direct input and stays off
// R17 - fail-input status bit in status register seven mirrors fail-mode pin
// R18 - fail-mode input deglitched, only a steady level of 200 us acts
// R19 - spi toggle error, watchdog timeout or frame length error enters fail mode
// R20 - spi failure flag set on error, held in fail, cleared leaving fail; code keeps it set when fail mode gives way to sleep
// R21 - supply, fail and wake levels synchronised before changing mode state
`timescale 1ns/1ps
module supply_mode_supervisor
    import supply_mode_pkg::*;
#(
    parameter int FAIL_DGL_CYC = FAIL_DGL_CYCLES
) (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    // supply monitors and wake condition
    input  wire supply_mode_pkg::supply_t      supplyLoss,
    input  wire logic                          wakeCond,
    // reset/wake input, low level active as a wake source
    input  wire logic                          resetWakeIn,
    input  wire logic                          wakeFromResetWake,
    // shared wake-report pin
    input  wire logic                          wakeReportIn,
    output logic                               wakeReportOut,
    output logic                               wakeReportOe,
    output logic                               wakeReportSample,
    // fail-mode pin and direct inputs
    input  wire logic                          failModeIn,
    input  wire logic [NUM_DIRECT_IN-1:0]      directChannelInputs,
    // pwm module and spi settings
    input  wire logic [NUM_POWER_OUT-1:0]      pwmChannels,
    input  wire logic                          extSwitchSetting,
    input  wire supply_mode_pkg::spi_fault_t   spiFault,
    input  wire logic                          failExitReq,
    // fault detector events and clear
    input  wire logic [FAULT_W-1:0]            faultEvents,
    input  wire logic [FAULT_W-1:0]            faultClear,
    // outputs
    output logic [NUM_POWER_OUT-1:0]           powerOutputs,
    output logic                               extSwitchOut,
    // status
    output supply_mode_pkg::mode_t             mode,
    output logic                               fullyOperational,
    output logic                               spiReadEnable,
    output logic                               wdTimeoutForced,
    output logic                               registerClear,
    output logic [FAULT_W-1:0]                 faultFlags,
    output supply_mode_pkg::status7_t          status7
);
    import supply_mode_pkg::*;

    localparam int SYNC_W = 6;

    initial begin
        if (FAIL_DGL_CYC < 1) $error("supply_mode_supervisor: FAIL_DGL_CYC below one");
        if (NUM_DIRECT_IN > NUM_POWER_OUT) $error("supply_mode_supervisor: too many direct inputs");
    end

    // synchronised copies of the slow levels
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] syncOut;
    supply_t           supS;
    logic              wakeS;
    logic              failPinS;
    logic              failFilt;

    assign syncIn = {supplyLoss, wakeCond, resetWakeIn, failModeIn};

    // every level that steers the mode passes two flops first, see R21
    level_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .asyncIn (syncIn),
        .syncOut (syncOut)
    );

    logic resetWakeS;
    assign supS       = supply_t'(syncOut[5:3]);
    assign wakeS      = syncOut[2];
    assign resetWakeS = syncOut[1];
    assign failPinS   = syncOut[0];

    // fail pin filtered; a short pulse never reaches the mode logic, see R18
    level_deglitch #(
        .CYCLES (FAIL_DGL_CYC)
    ) u_fail_dgl (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .levelIn  (failPinS),
        .levelOut (failFilt)
    );

    // derived supply conditions
    logic powerOffCond;
    logic batOnlyLost;
    logic logicOnlyLost;
    logic spiErr;
    logic failCause;

    assign powerOffCond  = supS.batLost & supS.logicLost;           // see R6
    assign batOnlyLost   = supS.batLost & ~supS.logicLost;          // see R7
    assign logicOnlyLost = supS.logicLost & ~supS.batLost;          // see R10
    assign spiErr        = spiFault.toggleErr | spiFault.timeout | spiFault.frameLenErr;
    // lost logic supply counts as a watchdog timeout, see R10
    assign failCause     = failFilt | spiErr | logicOnlyLost;       // see R15 see R19

    mode_t mode_ff;
    mode_t nxt_mode;

    // mode selection; power off outranks sleep, sleep outranks fail
    always_comb begin
        nxt_mode = mode_ff;
        if (powerOffCond) begin
            nxt_mode = MODE_OFF;                                      // see R6
        end else if (!wakeS) begin
            nxt_mode = MODE_SLEEP;                                    // see R1
        end else begin
            case (mode_ff)
                MODE_OFF, MODE_SLEEP: begin
                    nxt_mode = failCause ? MODE_FAIL : MODE_NORMAL;
                end
                MODE_NORMAL: begin
                    if (failCause) begin
                        nxt_mode = MODE_FAIL;                         // see R15 see R19
                    end
                end
                MODE_FAIL: begin
                    // leaving fail needs a good frame and no standing cause
                    if (!failCause && failExitReq) begin
                        nxt_mode = MODE_NORMAL;
                    end
                end
                default: nxt_mode = MODE_OFF;
            endcase
        end
    end

    // mode state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_ff <= MODE_OFF;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    logic inFail;
    logic inNormal;
    assign inFail   = (mode_ff == MODE_FAIL);
    assign inNormal = (mode_ff == MODE_NORMAL);

    // power output selection per channel, one flop each
    logic [NUM_POWER_OUT-1:0] powerOutputs_ff;
    logic                     outBlock;
    // battery or ground loss removes drive at once, see R7 see R11
    assign outBlock = supS.batLost | supS.gndLost;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_POWER_OUT; ch++) begin : g_chan
            logic directBit;
            if (ch < NUM_DIRECT_IN) begin : g_dir
                assign directBit = directChannelInputs[ch];
            end else begin : g_nodir
                // channel without a direct input stays off in fail mode
                assign directBit = 1'b0;
            end
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    powerOutputs_ff[ch] <= 1'b0;
                end else if (outBlock || powerOffCond) begin
                    powerOutputs_ff[ch] <= 1'b0;                      // see R6 see R7 see R11
                end else if (nxt_mode == MODE_FAIL) begin
                    powerOutputs_ff[ch] <= directBit;                 // see R14 see R16
                end else if (nxt_mode == MODE_NORMAL) begin
                    powerOutputs_ff[ch] <= pwmChannels[ch];           // see R12
                end else begin
                    powerOutputs_ff[ch] <= 1'b0;                      // see R1
                end
            end
        end
    endgenerate

    // external switch: normal mode only, kept on a battery loss with logic up
    logic extSwitch_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            extSwitch_ff <= 1'b0;
        end else if (supS.logicLost || supS.gndLost) begin
            extSwitch_ff <= 1'b0;
        end else if (supS.batLost || nxt_mode == MODE_NORMAL) begin
            extSwitch_ff <= extSwitchSetting;                         // see R8
        end else begin
            extSwitch_ff <= 1'b0;
        end
    end

    // sticky fault flags; a new event beats a clear in the same cycle
    logic [FAULT_W-1:0] faultFlags_ff;
    always_ff @(posedge ref_clk) begin
        if (srst || powerOffCond) begin
            faultFlags_ff <= FAULT_RST;                               // see R6
        end else begin
            faultFlags_ff <= (faultFlags_ff & ~faultClear) | faultEvents; // see R7 see R13
        end
    end

    // spi failure flag: set by error, held in fail, dropped on the move from fail to normal
    logic spiFail_ff;
    always_ff @(posedge ref_clk) begin
        if (srst || powerOffCond) begin
            spiFail_ff <= 1'b0;
        end else if (spiErr || logicOnlyLost) begin
            spiFail_ff <= 1'b1;                                       // see R20
        end else if (inFail && nxt_mode == MODE_NORMAL) begin
            spiFail_ff <= 1'b0;                                       // see R20
        end
    end

    // wake source capture and hiding of wake-ups during battery loss
    logic wakeS_ff;
    logic wokeByReset_ff;
    logic wakeHidden_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wakeS_ff       <= 1'b0;
            wokeByReset_ff <= 1'b0;
            wakeHidden_ff  <= 1'b0;
        end else begin
            wakeS_ff <= wakeS;
            if (!wakeS) begin
                wokeByReset_ff <= 1'b0;
                wakeHidden_ff  <= 1'b0;
            end else if (!wakeS_ff) begin
                // the source is decided at the rising edge of wake
                wokeByReset_ff <= wakeFromResetWake;
                wakeHidden_ff  <= supS.batLost;                       // see R9
            end
        end
    end

    // wake-report pin drive; held low resetWake marks the reporting window
    logic wakeReportOe_ff;
    logic wakeReportSample_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wakeReportOe_ff     <= 1'b0;
            wakeReportSample_ff <= 1'b0;
        end else begin
            wakeReportOe_ff <= !resetWakeS && wakeS && wakeS_ff && !wokeByReset_ff
                               && !wakeHidden_ff && !supS.batLost;   // see R2 see R3 see R4 see R9
            // pin is an input whenever it is not driven, see R4
            wakeReportSample_ff <= wakeReportOe_ff ? 1'b0 : wakeReportIn;
        end
    end

    // supply dependent status, registered to keep outputs glitch free
    logic spiReadEn_ff;
    logic wdForced_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            spiReadEn_ff <= 1'b0;
            wdForced_ff  <= 1'b0;
        end else begin
            spiReadEn_ff <= !supS.logicLost;                          // see R5
            wdForced_ff  <= logicOnlyLost;                            // see R10
        end
    end

    // status register seven mirrors the filtered fail pin level and the spi failure flag
    status7_t status7_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            status7_ff <= '0;
        end else begin
            status7_ff.failInput  <= failFilt;                        // see R17
            status7_ff.spiFailure <= spiFail_ff;
        end
    end

    // port assignments
    assign powerOutputs     = powerOutputs_ff;
    assign extSwitchOut     = extSwitch_ff;
    assign mode             = mode_ff;
    assign fullyOperational = inNormal | inFail;                      // see R1
    assign spiReadEnable    = spiReadEn_ff;
    assign wdTimeoutForced  = wdForced_ff;
    assign registerClear    = (mode_ff == MODE_OFF);                  // see R6
    assign faultFlags       = faultFlags_ff;
    assign status7          = status7_ff;
    assign wakeReportOut    = wakeReportOe_ff;
    assign wakeReportOe     = wakeReportOe_ff;
    assign wakeReportSample = wakeReportSample_ff;

    // checks on the supervisor
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence failToNormal;
        (mode_ff == MODE_FAIL) ##1 (mode_ff == MODE_NORMAL);
    endsequence

    sequence batLossHeld;
        batOnlyLost ##1 batOnlyLost;
    endsequence

    power_off_a: assert property (powerOffCond |=> powerOutputs_ff == OUT_OFF && faultFlags_ff == FAULT_RST
                                  && mode_ff == MODE_OFF) // see R6
        else $error("power off did not clear outputs and faults");
    bat_loss_a: assert property (batLossHeld |-> powerOutputs_ff == OUT_OFF && mode_ff != MODE_OFF) // see R7
        else $error("battery loss left outputs on or powered off");
    ext_follow_a: assert property (batOnlyLost && !supS.gndLost |=> extSwitch_ff == $past(extSwitchSetting)) // see R8
        else $error("external switch did not follow setting");
    gnd_off_a: assert property (supS.gndLost |=> powerOutputs_ff == OUT_OFF) // see R11
        else $error("ground loss left outputs on");
    fail_entry_a: assert property (inNormal && wakeS && !powerOffCond && (failFilt || spiErr)
                                   |=> mode_ff == MODE_FAIL) // see R15
        else $error("fail cause did not enter fail mode");
    fail_follow_a: assert property (inFail && nxt_mode == MODE_FAIL && !outBlock && !powerOffCond
                                    |=> powerOutputs_ff[NUM_DIRECT_IN-1:0] == $past(directChannelInputs)) // see R16
        else $error("fail mode outputs do not follow direct inputs");
    pwm_follow_a: assert property (nxt_mode == MODE_NORMAL && !outBlock && !powerOffCond
                                   |=> powerOutputs_ff == $past(pwmChannels)) // see R12
        else $error("normal mode outputs do not follow pwm");
    spi_failure_flag_set_a: assert property (spiErr && !powerOffCond |=> spiFail_ff ##1 status7_ff.spiFailure) // see R20
        else $error("spi failure flag not set");
    spi_failure_flag_clear_a: assert property (failToNormal and ##1 !$past(spiErr) |-> !spiFail_ff) // see R20
        else $error("spi failure flag not cleared leaving fail");
    wake_hide_a: assert property (wakeHidden_ff |=> !wakeReportOe_ff) // see R9
        else $error("wake during battery loss was reported");
    woke_reset_a: assert property (wokeByReset_ff |-> !wakeReportOe_ff) // see R4
        else $error("reset/wake wake-up was reported");
    wd_path_a: assert property (logicOnlyLost |=> wdForced_ff && !spiReadEn_ff) // see R10
        else $error("logic supply loss did not force watchdog path");
endmodule

// *** test/host_mcu_model.sv ***
// host controller model driving the device pins
`timescale 1ns/1ps
module host_mcu_model (
    // clock
    input  wire logic                                        ref_clk,
    // shared wake-report pin as driven by the device
    input  wire logic                                        wakeReportOut,
    input  wire logic                                        wakeReportOe,
    // pins driven by the host
    output logic                                             resetWakeIn,
    output logic                                             failModeIn,
    output logic [supply_mode_pkg::NUM_DIRECT_IN-1:0]        directChannelInputs,
    output logic                                             wakeReportIn
);
    import supply_mode_pkg::*;
    logic lastLvl;

    // pins start released: reset/wake inactive, fail-mode low
    initial begin
        resetWakeIn = 1'b1;
        failModeIn = 1'b0;
        directChannelInputs = '0;
        lastLvl = 1'b0;
    end

    // host drives the reset/wake, fail-mode and direct input pins
    task automatic drive(input logic rst, input logic fail, input logic [NUM_DIRECT_IN-1:0] dir);
        resetWakeIn = rst;
        failModeIn = fail;
        directChannelInputs = dir;
    endtask

    // an undriven pin has no pull: it shows the inverse of its last level
    always @(posedge ref_clk) begin
        lastLvl <= wakeReportIn;
    end
    assign wakeReportIn = wakeReportOe ? wakeReportOut : ~lastLvl;
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the supply and mode supervisor
`timescale 1ns/1ps
module tb_top;
    import supply_mode_pkg::*;
    localparam int DGL = 8;
    localparam logic [23:0] MALL = 24'hffffff;
    localparam logic [23:0] NOMODE = 24'h3ffeff;
    localparam logic [23:0] NOST7 = 24'hffcfff;
    localparam logic [23:0] NOST7OE = 24'hff0fff;
    logic ref_clk, srst, wakeCond, wakeFromResetWake, failExitReq, extSwitchSetting;
    logic resetWakeIn, failModeIn, wakeReportIn, wakeReportOut, wakeReportOe, wSmp;
    logic fullyOperational, spiReadEnable, wdTimeoutForced, registerClear, extSwitchOut;
    supply_t supplyLoss;
    spi_fault_t spiFault;
    mode_t mode;
    status7_t status7;
    logic [NUM_DIRECT_IN-1:0] directChannelInputs, d;
    logic [NUM_POWER_OUT-1:0] pwmChannels, powerOutputs;
    logic [FAULT_W-1:0] faultEvents, faultClear, faultFlags, f;
    logic [23:0] obs;
    logic [47:0] notes[$];
    logic [47:0] n;
    event resultSeen;
    int fails = 0;
    int cmp_count = 0;
    int seed = 14;

    supply_mode_supervisor #(.FAIL_DGL_CYC(DGL)) i_supply_mode_supervisor (
        .ref_clk, .srst, .supplyLoss, .wakeCond, .resetWakeIn, .wakeFromResetWake, .wakeReportIn,
        .wakeReportOut, .wakeReportOe, .wakeReportSample(wSmp), .failModeIn, .directChannelInputs,
        .pwmChannels, .extSwitchSetting, .spiFault, .failExitReq, .faultEvents, .faultClear,
        .powerOutputs, .extSwitchOut, .mode, .fullyOperational, .spiReadEnable, .wdTimeoutForced,
        .registerClear, .faultFlags, .status7
    );
    host_mcu_model i_host_mcu_model (
        .ref_clk, .wakeReportOut, .wakeReportOe, .resetWakeIn, .failModeIn, .directChannelInputs, .wakeReportIn
    );

    assign obs = {mode, powerOutputs, extSwitchOut, wakeReportOe, wakeReportOut, status7, spiReadEnable,
                  wdTimeoutForced, registerClear, fullyOperational, faultFlags};

    // clock toggles every half period
    always #5 ref_clk = ~ref_clk;

    function automatic logic [23:0] mk(mode_t m, logic [4:0] p, logic e, logic oe, logic [1:0] s, logic rd,
                                       logic wd, logic rc, logic fo, logic [7:0] fl);
        return {m, p, e, oe, oe, s, rd, wd, rc, fo, fl};
    endfunction
    function automatic logic [23:0] nrm(logic [4:0] p, logic oe, logic [7:0] fl);
        return mk(MODE_NORMAL, p, 1'b1, oe, 2'b00, 1'b1, 1'b0, 1'b0, 1'b1, fl);
    endfunction

    task automatic check(logic [23:0] seen, logic [23:0] exp, logic [23:0] msk);
        cmp_count++;
        if ((seen & msk) !== (exp & msk)) begin
            fails++;
            $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(logic [23:0] exp, logic [23:0] msk);
        notes.push_back({exp, msk});
        ->resultSeen;
    endtask
    task automatic step(int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // a bounded wait: running out counts as a mismatch and ends the run
    task automatic waitMode(mode_t m, int lim);
        for (int i = 0; i <= lim; i++) begin
            if (mode === m)
                return;
            step(1);
        end
        fails++;
        $display("mismatch t=%0t mode wait ran out", $time);
        results();
    endtask
    task automatic exitFail;
        failExitReq = 1'b1;
        step(1);
        failExitReq = 1'b0;
        step(2);
    endtask

    // watcher: each announced result is compared with the oldest note
    always begin
        @(resultSeen);
        n = notes.pop_front();
        check(obs, n[47:24], n[23:0]);
    end

    initial begin
        ref_clk = 1'b0; srst = 1'b1; wakeCond = 1'b1; wakeFromResetWake = 1'b0; failExitReq = 1'b0;
        extSwitchSetting = 1'b1; supplyLoss = '0; spiFault = '0; pwmChannels = 5'h00;
        faultEvents = 8'h00; faultClear = 8'h00; f = 8'h00; d = 4'($random(seed));
        step(7);
        i_host_mcu_model.drive(1'b1, 1'b0, d);
        note(mk(MODE_OFF, 5'h00, 0, 0, 2'b00, 0, 0, 1, 0, 8'h00), MALL);
        step(1);
        srst = 1'b0;
        step(5);
        // random pwm patterns pass through in normal mode, no report while reset/wake is high
        for (int i = 0; i < 4; i++) begin
            pwmChannels = 5'($random(seed));
            step(2);
            note(nrm(pwmChannels, 1'b0, f), MALL);
        end
        // every fault type latches, then a partial clear
        for (int i = 0; i < 8; i++) begin
            faultEvents = 8'h01 << i;
            step(1);
            faultEvents = 8'h00;
            f = f | (8'h01 << i);
            step(1);
            note(nrm(pwmChannels, 1'b0, f), MALL);
        end
        faultClear = 8'h3c;
        step(1);
        faultClear = 8'h00;
        f = 8'hc3;
        step(1);
        note(nrm(pwmChannels, 1'b0, f), MALL);
        // battery loss keeps faults, kills channels, external switch still follows its setting
        supplyLoss.batLost = 1'b1;
        step(4);
        note(mk(MODE_NORMAL, 5'h00, 1, 0, 2'b00, 1, 0, 0, 1, f), NOMODE);
        extSwitchSetting = 1'b0;
        step(2);
        note(mk(MODE_NORMAL, 5'h00, 0, 0, 2'b00, 1, 0, 0, 1, f), NOMODE);
        extSwitchSetting = 1'b1;
        // both supplies gone: power off, everything cleared
        supplyLoss.logicLost = 1'b1;
        step(4);
        note(mk(MODE_OFF, 5'h00, 0, 0, 2'b00, 0, 0, 1, 0, 8'h00), NOST7);
        supplyLoss = '0;
        step(5);
        note(nrm(pwmChannels, 1'b0, 8'h00), NOST7OE);
        // logic supply alone lost: watchdog path into fail mode
        supplyLoss.logicLost = 1'b1;
        step(4);
        note(mk(MODE_FAIL, {1'b0, d}, 0, 0, 2'b01, 0, 1, 0, 1, 8'h00), MALL);
        supplyLoss = '0;
        step(4);
        exitFail();
        note(nrm(pwmChannels, 1'b0, 8'h00), MALL);
        // ground loss
        supplyLoss.gndLost = 1'b1;
        step(4);
        note(mk(MODE_NORMAL, 5'h00, 0, 0, 2'b00, 1, 0, 0, 1, 8'h00), NOMODE);
        supplyLoss = '0;
        step(4);
        // short fail-pin pulse is filtered out, a steady one enters fail mode
        i_host_mcu_model.drive(1'b1, 1'b1, d);
        step(DGL - 3);
        i_host_mcu_model.drive(1'b1, 1'b0, d);
        step(DGL + 6);
        note(nrm(pwmChannels, 1'b0, 8'h00), MALL);
        i_host_mcu_model.drive(1'b1, 1'b1, d);
        waitMode(MODE_FAIL, DGL + 8);
        step(2);
        note(mk(MODE_FAIL, {1'b0, d}, 0, 0, 2'b10, 1, 0, 0, 1, 8'h00), MALL);
        d = 4'($random(seed));
        i_host_mcu_model.drive(1'b1, 1'b1, d);
        step(2);
        note(mk(MODE_FAIL, {1'b0, d}, 0, 0, 2'b10, 1, 0, 0, 1, 8'h00), MALL);
        exitFail();
        note(mk(MODE_FAIL, {1'b0, d}, 0, 0, 2'b10, 1, 0, 0, 1, 8'h00), MALL);
        i_host_mcu_model.drive(1'b1, 1'b0, d);
        step(DGL + 6);
        exitFail();
        note(nrm(pwmChannels, 1'b0, 8'h00), MALL);
        // each spi fault kind enters fail mode and sets the failure flag until exit
        for (int i = 0; i < 3; i++) begin
            spiFault = 3'b001 << i;
            step(1);
            spiFault = '0;
            step(2);
            note(mk(MODE_FAIL, {1'b0, d}, 0, 0, 2'b01, 1, 0, 0, 1, 8'h00), MALL);
            exitFail();
            note(nrm(pwmChannels, 1'b0, 8'h00), MALL);
        end
        // sleep, then wake-ups hidden by battery loss or caused by reset/wake
        wakeCond = 1'b0;
        step(4);
        note(mk(MODE_SLEEP, 5'h00, 0, 0, 2'b00, 1, 0, 0, 0, 8'h00), MALL);
        supplyLoss.batLost = 1'b1;
        i_host_mcu_model.drive(1'b0, 1'b0, d);
        wakeCond = 1'b1;
        step(4);
        supplyLoss = '0;
        step(4);
        note(nrm(pwmChannels, 1'b0, 8'h00), MALL);
        wakeCond = 1'b0;
        step(4);
        wakeFromResetWake = 1'b1;
        wakeCond = 1'b1;
        step(5);
        note(nrm(pwmChannels, 1'b0, 8'h00), MALL);
        wakeCond = 1'b0;
        step(4);
        wakeFromResetWake = 1'b0;
        wakeCond = 1'b1;
        step(5);
        note(nrm(pwmChannels, 1'b1, 8'h00), MALL);
        check(24'(wSmp), 24'h0, MALL);
        step(2);
        results();
    end
endmodule
